// file: program_space_data_access_tb.sv
// Self-checking bench for the program space data access bridge.
// Assumes the memory model answers reads one cycle after the request pulse.
`timescale 1ns/1ps
module program_space_data_access_tb;
	import psda_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cpu_req_valid = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic hready, hreadyout, hresp, cpu_req_ready, cpu_stall, cpu_rsp_valid;
	logic [15:0] cpu_rsp_data, dm_rdata, d;
	logic [23:0] pm_rdata;
	psda_cpu_req_type cpu_req = '0;
	psda_pm_req_type pm_req;
	psda_dm_req_type dm_req;
	int n_fail = 0;
	int tests_run = 0;
	int lat, nf, ns;
	// Single slave, so its ready is the bus ready.
	assign hready = hreadyout;
	always #2 clk = ~clk;
	psda_bridge i_psda_bridge (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout, .hresp, .hrdata, .cpu_req_valid, .cpu_req,
		.cpu_req_ready, .cpu_stall, .cpu_rsp_valid, .cpu_rsp_data, .pm_req, .pm_rdata,
		.dm_req, .dm_rdata);
	psda_mem_model i_psda_mem_model (.clk, .pm_req, .dm_req, .pm_rdata, .dm_rdata);
	task automatic close_out;
		$display("counts: %0d compared, %0d mismatched", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// Every wait is bounded; a hang ends the run as a mismatch.
	task automatic guard(input int n);
		if (n > 40) begin
			n_fail++;
			$display("unexpected at %0t: wait ran out", $time);
			close_out();
		end
	endtask
	task automatic wait_rdy(input logic cpu);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			guard(n);
		end while ((cpu ? cpu_req_ready : hready) !== 1'b1);
	endtask
	// One single-word transfer; read data is taken at the end of the data phase.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= HSIZE_WORD;
		wait_rdy(1'b0);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy(1'b0);
		rd = hrdata;
	endtask
	// Flags are byte mode, move class, in repeat, repeat edge; counts cycles and fetches.
	task automatic op(input psda_kind_type k, input logic [15:0] ea, input logic [3:0] f);
		cpu_req_valid <= 1'b1;
		cpu_req       <= '{k, ea, f[3], 16'hBEEF, f[2], f[1], f[0]};
		wait_rdy(1'b1);
		cpu_req_valid <= 1'b0;
		lat = 0;
		nf = 0;
		ns = 0;
		do begin
			@(posedge clk);
			lat++;
			nf += int'(pm_req.rd);
			ns += int'(cpu_stall);
			guard(lat);
		end while (cpu_rsp_valid !== 1'b1);
		d = cpu_rsp_data;
		chk(32'(ns), 32'(lat), "stall cycles");
	endtask
	function automatic logic [23:0] pw(input logic [23:0] a);
		return a ^ 24'h5AC33C;
	endfunction
	task automatic t_regs;
		ahb(1'b0, OFS_TABLE_PAGE, 32'h0);
		chk(rd, {24'h0, TABLE_PAGE_RST}, "page reset");
		ahb(1'b1, OFS_TABLE_PAGE, 32'h81);
		ahb(1'b0, OFS_TABLE_PAGE, 32'h0);
		chk(rd, 32'h81, "page readback");
		ahb(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		$display("test registers done");
	endtask
	// Window enabled with the effective address top bit set: tables must ignore it.
	task automatic t_table;
		logic [7:0] tp;
		logic [15:0] ea, e;
		logic [23:0] w;
		logic bm;
		ahb(1'b1, OFS_CORE_CTRL, 32'h4);
		for (int p = 0; p < 2; p++) begin
			tp = p[0] ? 8'h12 : 8'h81;
			ahb(1'b1, OFS_TABLE_PAGE, {24'h0, tp});
			for (int i = 0; i < 6; i++) begin
				bm = i > 1;
				ea = 16'h8F30 | 16'(i > 3);
				op(i[0] ? PSDA_TBL_RD_HI : PSDA_TBL_RD_LO, ea, {bm, 3'h0});
				w = pw({tp, ea});
				e = i[0] ? ((bm && ea[0]) ? 16'h0 : {8'h0, w[23:16]})
					: (!bm ? w[15:0] : {8'h0, ea[0] ? w[15:8] : w[7:0]});
				chk(32'(d), 32'(e), "table data");
				chk(32'(lat), 32'd3, "table latency");
			end
			op(PSDA_TBL_WT_LO, 16'h9002, 4'h0);
			chk(32'(lat), 32'd2, "write low latency");
			op(PSDA_TBL_WT_HI, 16'h9003, 4'h8);
			chk(32'(lat), 32'd2, "write high latency");
		end
		$display("test table done");
	endtask
	task automatic t_window;
		logic [3:0] fl[4] = '{4'h4, 4'h0, 4'h3, 4'h2};
		int el[4] = '{4, 5, 5, 3};
		logic [15:0] ea;
		logic [23:0] w;
		// This page makes the model's upper byte zero, as padded constants would be.
		ahb(1'b1, OFS_VIS_PAGE, 32'hB5);
		for (int i = 0; i < 4; i++) begin
			ea = 16'hC123 + 16'(i * 2);
			op(PSDA_DATA_RD, ea, fl[i]);
			w = pw({1'b0, 8'hB5, ea[14:0]});
			chk(32'(d), 32'(w[15:0]), "window data");
			chk(32'(lat), 32'(el[i]), "window latency");
			chk(32'(nf), (el[i] > 3) ? 32'd2 : 32'd1, "window fetches");
		end
		ahb(1'b0, OFS_LAST_ADDR, 32'h0);
		chk(rd, 32'({1'b0, 8'hB5, ea[14:0]}), "last window address");
		op(PSDA_DATA_WR, 16'h8004, 4'h0);
		chk(32'(lat), 32'd2, "window write latency");
		ahb(1'b0, OFS_STATUS, 32'h0);
		chk(32'(rd[STAT_BLOCKED_BIT]), 32'd1, "write blocked flag");
		ahb(1'b1, OFS_STATUS, 32'h2);
		ahb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h0, "blocked flag cleared");
		$display("test window done");
	endtask
	task automatic t_plain;
		op(PSDA_DATA_RD, 16'h7FFE, 4'h4);
		chk(32'(d), 32'h7FFE ^ 32'h5AA5, "low half data");
		chk(32'(lat), 32'd3, "low half latency");
		ahb(1'b1, OFS_CORE_CTRL, 32'h0);
		op(PSDA_DATA_RD, 16'hC000, 4'h0);
		chk(32'(d), 32'hC000 ^ 32'h5AA5, "disabled window data");
		chk(32'(lat), 32'd3, "disabled window latency");
		op(PSDA_DATA_WR, 16'hC002, 4'h0);
		chk(32'(lat), 32'd2, "plain write latency");
		$display("test plain done");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_table();
		t_window();
		t_plain();
		close_out();
	end
endmodule

// file: psda_bridge.sv
// Program space data access bridge: forms program addresses for table operations
// and the visibility window, shapes read data and adds the visibility penalty cycles.
// Assumes program and data memories answer a read one cycle after the request,
// and that the CPU holds a request until it sees ready.
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps

module psda_bridge (
	// Clock and reset.
	input  wire logic                       clk,
	input  wire logic                       rstn,
	// AHB-Lite register slave.
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic                            hreadyout,
	output logic                            hresp,
	output logic [31:0]                     hrdata,
	// CPU data path.
	input  wire logic                       cpu_req_valid,
	input  wire psda_pkg::psda_cpu_req_type cpu_req,
	output logic                            cpu_req_ready,
	output logic                            cpu_stall,
	output logic                            cpu_rsp_valid,
	output logic [15:0]                     cpu_rsp_data,
	// Program memory.
	output psda_pkg::psda_pm_req_type       pm_req,
	input  wire logic [23:0]                pm_rdata,
	// Data memory.
	output psda_pkg::psda_dm_req_type       dm_req,
	input  wire logic [15:0]                dm_rdata
);
	import psda_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_CAPTURE, ST_PENALTY, ST_RESPOND} psda_state_type;

	// Register file state.
	logic [7:0]  table_page_select_reg;
	logic [7:0]  table_page_select_next;
	logic [7:0]  visibility_page_select_reg;
	logic [7:0]  visibility_page_select_next;
	logic [7:0]  core_control_reg;
	logic [7:0]  core_control_next;
	logic        blocked_reg;
	logic        blocked_next;
	logic [23:0] last_addr_reg;
	logic [23:0] last_addr_next;
	logic        wr_pend_reg;
	logic        wr_pend_next;
	logic [7:0]  wr_addr_reg;
	logic [7:0]  wr_addr_next;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;

	// Engine state.
	psda_state_type   state_reg;
	psda_state_type   state_next;
	psda_cpu_req_type op_reg;
	psda_cpu_req_type op_next;
	logic             vis_reg;
	logic             vis_next;
	logic [1:0]       extra_reg;
	logic [1:0]       extra_next;
	logic [1:0]       count_reg;
	logic [1:0]       count_next;
	logic [15:0]      rdata_reg;
	logic [15:0]      rdata_next;
	psda_pm_req_type  pm_req_reg;
	psda_pm_req_type  pm_req_next;
	psda_dm_req_type  dm_req_reg;
	psda_dm_req_type  dm_req_next;

	// Decode of the incoming request.
	logic             accept;
	logic             visibility_enable;
	logic             vis_hit;
	logic             is_table;
	logic [23:0]      table_addr;
	logic [23:0]      vis_addr;
	logic             ahb_take;
	logic             blocked_set;
	logic             bsel;

	// Register read mux; the bits above each register's width read as zero.
	function automatic logic [31:0] reg_read(input logic [7:0] ofs,
	                                         input logic [7:0] tps,
	                                         input logic [7:0] vps,
	                                         input logic [7:0] core,
	                                         input logic       busy,
	                                         input logic       blk,
	                                         input logic [23:0] last);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (ofs)
			OFS_TABLE_PAGE: v[7:0] = tps;
			OFS_VIS_PAGE:   v[7:0] = vps;
			OFS_CORE_CTRL:  v[7:0] = core;
			OFS_STATUS: begin
				v[STAT_BUSY_BIT]    = busy;
				v[STAT_BLOCKED_BIT] = blk;
			end
			OFS_LAST_ADDR:  v[23:0] = last;
			default:        v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// Shapes a program word into the 16-bit data result for each read kind.
	function automatic logic [15:0] shape(input psda_kind_type kind,
	                                      input logic byte_mode,
	                                      input logic sel,
	                                      input logic [23:0] p);
		logic [15:0] d;
		d = 16'h0000;
		if (kind == PSDA_TBL_RD_HI) begin
			if (!(byte_mode && sel)) begin
				d[7:0] = p[23:16];
			end
		end else if (byte_mode) begin
			d[7:0] = sel ? p[15:8] : p[7:0];
		end else begin
			d = p[15:0];
		end
		return d;
	endfunction

	// Extra cycles for a visibility read, by instruction class and repeat position.
	function automatic logic [1:0] penalty(input logic move, input logic rpt, input logic edge_it);
		logic [1:0] e;
		e = EXTRA_OTHER;
		if (!rpt) begin
			e = move ? EXTRA_MOVE : EXTRA_OTHER;
		end else begin
			e = edge_it ? EXTRA_RPT_EDGE : EXTRA_RPT_MID;
		end
		return e;
	endfunction

	// Address formation and routing decode, purely combinational from the request.
	assign visibility_enable = core_control_reg[CORE_VIS_BIT];
	assign is_table   = (cpu_req.kind != PSDA_DATA_RD) && (cpu_req.kind != PSDA_DATA_WR);
	assign vis_hit    = !is_table && visibility_enable && cpu_req.effective_address[EA_MSB];
	assign table_addr = {table_page_select_reg, cpu_req.effective_address};
	assign vis_addr   = {1'b0, visibility_page_select_reg, cpu_req.effective_address[14:0]};
	assign accept     = cpu_req_valid && (state_reg == ST_IDLE);
	assign bsel       = op_reg.effective_address[BYTE_SEL_BIT];
	assign ahb_take   = hsel && htrans[HTRANS_ACT_BIT] && hready;
	assign blocked_set = accept && vis_hit && (cpu_req.kind == PSDA_DATA_WR);

	// Engine next state. Only one access is in flight, so the CPU stalls meanwhile.
	always_comb begin
		state_next     = state_reg;
		op_next        = op_reg;
		vis_next       = vis_reg;
		extra_next     = extra_reg;
		count_next     = count_reg;
		rdata_next     = rdata_reg;
		last_addr_next = last_addr_reg;
		pm_req_next    = '0;
		dm_req_next    = '0;
		unique case (state_reg)
			ST_IDLE: begin
				if (accept) begin
					op_next    = cpu_req;
					vis_next   = vis_hit;
					extra_next = penalty(cpu_req.transfer_move, cpu_req.in_repeat,
					                     cpu_req.repeat_edge);
					count_next = 2'h0;
					state_next = ST_ISSUE;
					unique case (cpu_req.kind)
						PSDA_DATA_RD: begin
							if (vis_hit) begin
								pm_req_next.rd   = 1'b1;
								pm_req_next.addr = vis_addr;
								last_addr_next   = vis_addr;
							end else begin
								dm_req_next.rd        = 1'b1;
								dm_req_next.addr      = cpu_req.effective_address;
								dm_req_next.byte_mode = cpu_req.byte_mode;
							end
						end
						PSDA_DATA_WR: begin
							// A write into the window is dropped; it never reaches program memory.
							if (!vis_hit) begin
								dm_req_next.wr        = 1'b1;
								dm_req_next.addr      = cpu_req.effective_address;
								dm_req_next.wdata     = cpu_req.wdata;
								dm_req_next.byte_mode = cpu_req.byte_mode;
							end
						end
						PSDA_TBL_RD_LO, PSDA_TBL_RD_HI: begin
							pm_req_next.rd           = 1'b1;
							pm_req_next.addr         = table_addr;
							pm_req_next.config_space = table_page_select_reg[PAGE_CFG_BIT];
							last_addr_next           = table_addr;
						end
						PSDA_TBL_WT_LO: begin
							pm_req_next.wr           = 1'b1;
							pm_req_next.addr         = table_addr;
							pm_req_next.config_space = table_page_select_reg[PAGE_CFG_BIT];
							pm_req_next.wdata        = {8'h00, cpu_req.wdata};
							pm_req_next.wmask        = PM_MASK_WORD;
							if (cpu_req.byte_mode) begin
								pm_req_next.wdata = {8'h00, cpu_req.wdata[7:0], cpu_req.wdata[7:0]};
								pm_req_next.wmask = cpu_req.effective_address[BYTE_SEL_BIT] ?
								                    PM_MASK_MID : PM_MASK_LOW;
							end
							last_addr_next = table_addr;
						end
						PSDA_TBL_WT_HI: begin
							// The phantom byte has no storage, so a byte write to it writes nothing.
							pm_req_next.wr           = 1'b1;
							pm_req_next.addr         = table_addr;
							pm_req_next.config_space = table_page_select_reg[PAGE_CFG_BIT];
							pm_req_next.wdata        = {cpu_req.wdata[7:0], 16'h0000};
							pm_req_next.wmask        = PM_MASK_HIGH;
							if (cpu_req.byte_mode && cpu_req.effective_address[BYTE_SEL_BIT]) begin
								pm_req_next.wmask = PM_MASK_NONE;
							end
							last_addr_next = table_addr;
						end
						default: begin
							state_next = ST_RESPOND;
						end
					endcase
				end
			end
			ST_ISSUE: begin
				if (op_reg.kind == PSDA_DATA_WR || op_reg.kind == PSDA_TBL_WT_LO ||
				    op_reg.kind == PSDA_TBL_WT_HI) begin
					state_next = ST_RESPOND;
				end else begin
					state_next = ST_CAPTURE;
				end
			end
			ST_CAPTURE: begin
				if (op_reg.kind == PSDA_DATA_RD && !vis_reg) begin
					rdata_next = dm_rdata;
					state_next = ST_RESPOND;
				end else begin
					rdata_next = shape(op_reg.kind, op_reg.byte_mode, bsel, pm_rdata);
					state_next = (vis_reg && extra_reg != 2'h0) ? ST_PENALTY : ST_RESPOND;
				end
			end
			ST_PENALTY: begin
				// The first penalty cycle requests the second program fetch of the window; it shows on pm_req one cycle later.
				if (count_reg == 2'h0) begin
					pm_req_next.rd   = 1'b1;
					pm_req_next.addr = last_addr_reg;
				end
				count_next = count_reg + 2'h1;
				if (count_reg + 2'h1 == extra_reg) begin
					state_next = ST_RESPOND;
				end
			end
			ST_RESPOND: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Engine registers.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg     <= ST_IDLE;
			op_reg        <= '0;
			vis_reg       <= 1'b0;
			extra_reg     <= 2'h0;
			count_reg     <= 2'h0;
			rdata_reg     <= 16'h0000;
			last_addr_reg <= 24'h00_0000;
			pm_req_reg    <= '0;
			dm_req_reg    <= '0;
		end else begin
			state_reg     <= state_next;
			op_reg        <= op_next;
			vis_reg       <= vis_next;
			extra_reg     <= extra_next;
			count_reg     <= count_next;
			rdata_reg     <= rdata_next;
			last_addr_reg <= last_addr_next;
			pm_req_reg    <= pm_req_next;
			dm_req_reg    <= dm_req_next;
		end
	end

	// Register file next values. A write lands in its data phase; reads are taken
	// from the next values so a read right behind a write sees the new contents.
	always_comb begin
		table_page_select_next      = table_page_select_reg;
		visibility_page_select_next = visibility_page_select_reg;
		core_control_next           = core_control_reg;
		blocked_next                = blocked_reg;
		wr_pend_next                = ahb_take && hwrite && (hsize == HSIZE_WORD);
		wr_addr_next                = haddr[7:0];
		hrdata_next                 = hrdata_reg;
		if (wr_pend_reg) begin
			unique case (wr_addr_reg)
				OFS_TABLE_PAGE: table_page_select_next = hwdata[7:0];
				OFS_VIS_PAGE:   visibility_page_select_next = hwdata[7:0];
				OFS_CORE_CTRL:  core_control_next = hwdata[7:0];
				OFS_STATUS: begin
					if (hwdata[STAT_BLOCKED_BIT]) begin
						blocked_next = 1'b0;
					end
				end
				default: begin
					blocked_next = blocked_next;
				end
			endcase
		end
		// A blocked write in the same cycle as a clear keeps the flag set.
		if (blocked_set) begin
			blocked_next = 1'b1;
		end
		if (ahb_take && !hwrite) begin
			hrdata_next = reg_read(haddr[7:0], table_page_select_next,
			                       visibility_page_select_next, core_control_next,
			                       state_next != ST_IDLE, blocked_next, last_addr_next);
		end
	end

	// Register file registers.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			table_page_select_reg      <= TABLE_PAGE_RST;
			visibility_page_select_reg <= VIS_PAGE_RST;
			core_control_reg           <= CORE_CTRL_RST;
			blocked_reg                <= 1'b0;
			wr_pend_reg                <= 1'b0;
			wr_addr_reg                <= 8'h00;
			hrdata_reg                 <= 32'h0000_0000;
		end else begin
			table_page_select_reg      <= table_page_select_next;
			visibility_page_select_reg <= visibility_page_select_next;
			core_control_reg           <= core_control_next;
			blocked_reg                <= blocked_next;
			wr_pend_reg                <= wr_pend_next;
			wr_addr_reg                <= wr_addr_next;
			hrdata_reg                 <= hrdata_next;
		end
	end

	// Outputs. The slave never waits, so every transfer completes in one data phase.
	assign hreadyout     = 1'b1;
	assign hresp         = HRESP_OKAY;
	assign hrdata        = hrdata_reg;
	assign cpu_req_ready = (state_reg == ST_IDLE);
	assign cpu_stall     = (state_reg != ST_IDLE);
	assign cpu_rsp_valid = (state_reg == ST_RESPOND);
	assign cpu_rsp_data  = rdata_reg;
	assign pm_req        = pm_req_reg;
	assign dm_req        = dm_req_reg;

endmodule

// file: psda_bridge_props.sv
// Checker for the program space data access bridge, bound to its ports.
// Assumes one clock, synchronous active-low reset and a zero-wait register bus.
`timescale 1ns/1ps
module psda_bridge_chk
	import psda_pkg::*;
(
	// Clock and reset.
	input wire logic             clk,
	input wire logic             rstn,
	// Register bus.
	input wire logic             hsel,
	input wire logic [31:0]      haddr,
	input wire logic [1:0]       htrans,
	input wire logic             hwrite,
	input wire logic [2:0]       hsize,
	input wire logic [31:0]      hwdata,
	input wire logic             hready,
	// CPU and memory sides.
	input wire logic             cpu_req_valid,
	input wire psda_cpu_req_type cpu_req,
	input wire logic             cpu_req_ready,
	input wire logic             cpu_rsp_valid,
	input wire psda_pm_req_type  pm_req,
	input wire psda_dm_req_type  dm_req
);
	logic       wp_reg;
	logic [7:0] wa_reg, tps_reg, vps_reg, core_reg;
	logic       take, vis, win, tbl;
	// Shadow copies of the page and control registers, so addresses can be predicted.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wp_reg   <= 1'h0;
			tps_reg  <= 8'h00;
			vps_reg  <= 8'h00;
			core_reg <= 8'h00;
		end else begin
			wp_reg <= hsel & htrans[1] & hready & hwrite & (hsize == HSIZE_WORD);
			wa_reg <= haddr[7:0];
			if (wp_reg && wa_reg == OFS_TABLE_PAGE) tps_reg <= hwdata[7:0];
			if (wp_reg && wa_reg == OFS_VIS_PAGE) vps_reg <= hwdata[7:0];
			if (wp_reg && wa_reg == OFS_CORE_CTRL) core_reg <= hwdata[7:0];
		end
	end
	// Request classes at the edge where the bridge takes a request.
	assign take = cpu_req_valid & cpu_req_ready;
	assign vis  = core_reg[CORE_VIS_BIT] & cpu_req.effective_address[EA_MSB];
	assign win  = take & (cpu_req.kind == PSDA_DATA_RD) & vis;
	assign tbl  = take & (cpu_req.kind > PSDA_DATA_WR);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_tbl_addr;
		tbl |=> (pm_req.rd | pm_req.wr) && pm_req.config_space == tps_reg[PAGE_CFG_BIT]
			&& pm_req.addr == {tps_reg, $past(cpu_req.effective_address)};
	endproperty
	a_tbl_addr: assert property (p_tbl_addr)
		else $error("table address wrong");
	property p_tbl_rd;
		tbl && cpu_req.kind < PSDA_TBL_WT_LO |=> !dm_req.rd ##2 cpu_rsp_valid;
	endproperty
	a_tbl_rd: assert property (p_tbl_rd)
		else $error("table read timing wrong");
	property p_win_addr;
		win |=> pm_req.rd && !pm_req.wr
			&& pm_req.addr == {1'b0, vps_reg, $past(cpu_req.effective_address[14:0])};
	endproperty
	a_win_addr: assert property (p_win_addr)
		else $error("window address wrong");
	// The second fetch is registered, so it shows in the answer cycle itself.
	property p_win_move;
		win && !cpu_req.in_repeat && cpu_req.transfer_move |=> pm_req.rd
			##1 !cpu_rsp_valid [*2] ##1 pm_req.rd && cpu_rsp_valid;
	endproperty
	a_win_move: assert property (p_win_move)
		else $error("window move penalty wrong");
	property p_win_other;
		win && !cpu_req.in_repeat && !cpu_req.transfer_move |=> !cpu_rsp_valid [*4] ##1 cpu_rsp_valid;
	endproperty
	a_win_other: assert property (p_win_other)
		else $error("window penalty wrong");
	property p_rpt_edge;
		win && cpu_req.in_repeat && cpu_req.repeat_edge |-> ##5 cpu_rsp_valid;
	endproperty
	a_rpt_edge: assert property (p_rpt_edge)
		else $error("repeat edge penalty wrong");
	property p_rpt_mid;
		win && cpu_req.in_repeat && !cpu_req.repeat_edge |-> ##3 cpu_rsp_valid;
	endproperty
	a_rpt_mid: assert property (p_rpt_mid)
		else $error("repeat middle timing wrong");
	property p_win_wr;
		take && cpu_req.kind == PSDA_DATA_WR && vis |=> !pm_req.wr && !dm_req.wr ##1 cpu_rsp_valid;
	endproperty
	a_win_wr: assert property (p_win_wr)
		else $error("window write not dropped");
	property p_plain;
		take && cpu_req.kind == PSDA_DATA_RD && !vis |=> dm_req.rd && !pm_req.rd ##2 cpu_rsp_valid;
	endproperty
	a_plain: assert property (p_plain)
		else $error("plain read wrong");
	property p_plain_wr;
		take && cpu_req.kind == PSDA_DATA_WR && !vis |=> dm_req.wr && !pm_req.wr
			&& dm_req.addr == $past(cpu_req.effective_address) ##1 cpu_rsp_valid;
	endproperty
	a_plain_wr: assert property (p_plain_wr)
		else $error("plain write wrong");
endmodule

bind psda_bridge psda_bridge_chk i_psda_bridge_chk (.clk, .rstn, .hsel, .haddr, .htrans,
	.hwrite, .hsize, .hwdata, .hready, .cpu_req_valid, .cpu_req, .cpu_req_ready,
	.cpu_rsp_valid, .pm_req, .dm_req);

// file: psda_mem_model.sv
// Program and data memory stand-ins facing the bridge.
// Assumes each read pulse is answered in the following cycle.
`timescale 1ns/1ps
module psda_mem_model
	import psda_pkg::*;
(
	// Requests from the bridge.
	input  wire logic            clk,
	input  wire psda_pm_req_type pm_req,
	input  wire psda_dm_req_type dm_req,
	// Read data returned.
	output logic [23:0]          pm_rdata,
	output logic [15:0]          dm_rdata
);
	// Contents are a fixed function of the address; outside the answer cycle the
	// lines toggle, so a bridge that samples late never sees stale data as valid.
	always_ff @(posedge clk) begin
		pm_rdata <= pm_req.rd ? (pm_req.addr ^ 24'h5AC33C) : ~pm_rdata;
		dm_rdata <= dm_req.rd ? (dm_req.addr ^ 16'h5AA5) : ~dm_rdata;
	end
endmodule

// file: psda_pkg.sv
// Functional notes
// - Table address is page above effective address.
// - Page bit 7 selects configuration memory.
// - Visibility address is page above EA low 15.
// - Visibility only when EA bit 15 and enable.
// - EA bit 15 dropped; page bit 0 forms bit 15.
// - Visibility path is user-space and read-only.
// - Visibility returns program word bits 15:0.
// - Visibility read needs two program fetches; the bridge issues only one for a mid-repeat read.
// - Outside repeat: moves plus one, others plus two.
// - Repeat edges plus two, other iterations none.
// - Table operations never use visibility mapping.
// - Word low read returns bits 15:0.
// - Byte low read picks byte by select bit.
// - Word high read returns bits 23:16, upper zero.
// - Byte high read of phantom byte is zero.
// - Program addresses step by two per word.
// - Any byte address; configuration reads allowed.
//
// Package of the program space data access bridge: register map, field positions,
// penalty counts, request kinds and the carrier structs shared by the design.
// Assumes a single core clock domain and word-wide AHB-Lite register access.
package psda_pkg;

	// Register byte offsets on the AHB-Lite slave.
	localparam logic [7:0] OFS_TABLE_PAGE = 8'h00;
	localparam logic [7:0] OFS_VIS_PAGE   = 8'h04;
	localparam logic [7:0] OFS_CORE_CTRL  = 8'h08;
	localparam logic [7:0] OFS_STATUS     = 8'h0C;
	localparam logic [7:0] OFS_LAST_ADDR  = 8'h10;

	// Reset values.
	localparam logic [7:0] TABLE_PAGE_RST = 8'h00;
	localparam logic [7:0] VIS_PAGE_RST   = 8'h00;
	localparam logic [7:0] CORE_CTRL_RST  = 8'h00;

	// Field positions.
	localparam int CORE_VIS_BIT     = 2;
	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_BLOCKED_BIT = 1;
	localparam int EA_MSB           = 15;
	localparam int PAGE_CFG_BIT     = 7;
	localparam int BYTE_SEL_BIT     = 0;
	localparam int HTRANS_ACT_BIT   = 1;

	// Bus encodings.
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic       HRESP_OKAY = 1'h0;

	// Extra cycles added to a visibility read.
	localparam logic [1:0] EXTRA_MOVE     = 2'h1;
	localparam logic [1:0] EXTRA_OTHER    = 2'h2;
	localparam logic [1:0] EXTRA_RPT_EDGE = 2'h2;
	localparam logic [1:0] EXTRA_RPT_MID  = 2'h0;

	// Program memory byte-lane masks.
	localparam logic [2:0] PM_MASK_NONE = 3'h0;
	localparam logic [2:0] PM_MASK_LOW  = 3'h1;
	localparam logic [2:0] PM_MASK_MID  = 3'h2;
	localparam logic [2:0] PM_MASK_WORD = 3'h3;
	localparam logic [2:0] PM_MASK_HIGH = 3'h4;

	typedef enum logic [2:0] {
		PSDA_DATA_RD, PSDA_DATA_WR, PSDA_TBL_RD_LO, PSDA_TBL_RD_HI, PSDA_TBL_WT_LO, PSDA_TBL_WT_HI
	} psda_kind_type;

	typedef struct packed {
		psda_kind_type kind;
		logic [15:0]   effective_address;
		logic          byte_mode;
		logic [15:0]   wdata;
		logic          transfer_move;
		logic          in_repeat;
		logic          repeat_edge;
	} psda_cpu_req_type;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [23:0] addr;
		logic        config_space;
		logic [23:0] wdata;
		logic [2:0]  wmask;
	} psda_pm_req_type;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        byte_mode;
	} psda_dm_req_type;

endpackage
